// *** shared/ovstr_pkg.sv ***
// constants for the otg voltage and system threshold register block
package ovstr_pkg;
    // byte addresses on the register port
    localparam logic [7:0]  ADDR_OTG_LO        = 8'h06;
    localparam logic [7:0]  ADDR_OTG_HI        = 8'h07;
    localparam logic [7:0]  ADDR_SYS_CTRL      = 8'h3e;
    // values after reset
    localparam logic [15:0] OTG_RESET          = 16'h09c4;
    localparam logic [7:0]  OTG_LO_STAGE_RESET = 8'hc4;
    localparam logic [7:0]  SYS_RESET_MULTI    = 8'h2c;
    localparam logic [7:0]  SYS_RESET_SINGLE   = 8'h04;
    // field positions of the system control byte
    localparam int          SYS_FIELD_MSB      = 7;
    localparam int          SYS_FIELD_LSB      = 2;
    localparam int          TRACK_BIT          = 1;
    localparam int          SWAP_BIT           = 0;
    // field positions of the otg voltage word
    localparam int          OTG_FIELD_MSB      = 13;
    localparam int          OTG_FIELD_LSB      = 2;
    localparam int          OTG_RSVD_MSB       = 15;
    localparam int          OTG_RSVD_LSB       = 14;
    // voltage scaling in millivolts
    localparam logic [15:0] OTG_STEP_MV        = 16'h0008;
    localparam logic [15:0] OTG_MIN_MV         = 16'h0bb8;
    localparam logic [15:0] OTG_MAX_MV         = 16'h5dc0;
    localparam logic [15:0] SYS_OFFSET_MV      = 16'h0c80;
    localparam logic [15:0] SYS_STEP_MV        = 16'h0064;
    localparam logic [15:0] SYS_SINGLE_MAX_MV  = 16'h0f3c;
    // power stage blanking after fast swap enable rises, at a 250 MHz core clock
    localparam int          CLK_MHZ            = 250;
    localparam int          BLANK_TIME_US      = 200;
    localparam int          BLANK_CYCLES       = BLANK_TIME_US * CLK_MHZ;
    localparam int          BLANK_CNT_W        = 16;
endpackage

// *** shared/ovstr_timer_if.sv ***
// carrier between the register block and its blanking timer
`timescale 1ns/10ps
`default_nettype none
interface ovstr_timer_if;
    logic                               start;
    logic [ovstr_pkg::BLANK_CNT_W-1:0] length;
    logic                               busy;
    modport ctrl (output start, output length, input busy);
    modport timer (input start, input length, output busy);
endinterface
`default_nettype wire

// *** hw/ovstr_blank_timer.sv ***
// one-shot timer that holds busy for a programmed number of cycles
`timescale 1ns/10ps
`default_nettype none
module ovstr_blank_timer (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   srst,
    // control side
    ovstr_timer_if.timer tmr
);
    logic [ovstr_pkg::BLANK_CNT_W-1:0] cnt_reg;
    logic                               busy_reg;

    // a start restarts the window; busy stands for exactly length cycles
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else if (tmr.start) begin
            cnt_reg  <= tmr.length - 1'b1;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    assign tmr.busy = busy_reg;
endmodule
`default_nettype wire

// *** hw/ovstr_regs.sv ***
// otg voltage setpoint and system droop threshold control registers
`timescale 1ns/10ps
`default_nettype none
// How it works
// - threshold field bits 7:2, bits 5..2 weigh 800/400/200/100 mV.
// - reset loads bits 5,3 as 1 for multi-cell, 0 single-cell; bit 2 always 1.
// - tracking bit set makes second threshold copy the first threshold; resets off.
// - bit 0 enables fast role swap; off after reset.
// - swap enable rising blanks the power stage about 200 us.
// - high impedance enable forces the swap enable bit to zero.
// - otg field bits 13:2 decode at 8 mV per step up to 32760 mV.
// - setpoint clamped to 3 V .. 24 V; out-of-range writes ignored.
// - otg setpoint resets to 09c4h, i.e. 5000 mV.
// - a one in reserved bits 15:14 makes the write invalid.
// - reserved bits 1:0 of the setpoint are ignored on write.
// - threshold adds a fixed 3.2 V offset to the code.
// - single cell uses only low three code bits, top 3.9 V.
module ovstr_regs #(
    parameter int unsigned BLANK_CYCLES = ovstr_pkg::BLANK_CYCLES
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // register port from the serial interface engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr_en,
    input  wire logic [7:0]  reg_wr_data,
    input  wire logic        reg_rd_en,
    output logic      [7:0]  reg_rd_data,
    output logic             reg_rd_valid,
    // device configuration and state
    input  wire logic        cell_single_config,
    input  wire logic        high_impedance_enable,
    input  wire logic [15:0] sys_droop_threshold_first_mv,
    // decoded controls
    output logic      [15:0] sys_droop_threshold_second_mv,
    output logic             threshold_track_enable,
    output logic             fast_swap_enable,
    output logic             power_stage_disable,
    output logic      [15:0] otg_voltage_mv,
    output logic             otg_write_rejected
);
    ovstr_timer_if tmr_if ();

    logic [7:0]  sys_ctrl_reg;
    logic [7:0]  sys_ctrl_next;
    logic [15:0] otg_reg;
    logic [7:0]  otg_lo_stage_reg;
    logic        single_reg;
    logic [7:0]  rd_data_reg;
    logic        rd_valid_reg;
    logic [15:0] second_mv_reg;
    logic [15:0] otg_mv_reg;
    logic        rejected_reg;
    logic        wr_sys;
    logic        wr_otg_lo;
    logic        wr_otg_hi;
    logic [15:0] otg_cand;
    logic [15:0] otg_cand_mv;
    logic        otg_cand_rsvd;
    logic        otg_cand_ok;
    logic        swap_rise;
    logic [5:0]  sys_code;
    logic [5:0]  sys_code_eff;
    logic [15:0] sys_own_mv;
    logic [15:0] otg_dec_mv;

    // write strobes decoded from the byte address
    always_comb begin
        wr_sys    = 1'b0;
        wr_otg_lo = 1'b0;
        wr_otg_hi = 1'b0;
        if (reg_wr_en && reg_addr == ovstr_pkg::ADDR_SYS_CTRL) begin
            wr_sys = 1'b1;
        end else if (reg_wr_en && reg_addr == ovstr_pkg::ADDR_OTG_LO) begin
            wr_otg_lo = 1'b1;
        end else if (reg_wr_en && reg_addr == ovstr_pkg::ADDR_OTG_HI) begin
            wr_otg_hi = 1'b1;
        end
    end

    // cell strap is caught while reset is held
    always_ff @(posedge core_clk) begin
        if (srst) begin
            single_reg <= cell_single_config;
        end
    end

    // next value of the control byte; high impedance overrides the swap bit
    always_comb begin
        sys_ctrl_next = sys_ctrl_reg;
        if (wr_sys) begin
            sys_ctrl_next = reg_wr_data;
        end
        if (high_impedance_enable) begin
            sys_ctrl_next[ovstr_pkg::SWAP_BIT] = 1'b0;
        end
    end

    // control byte with cell-dependent reset value
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sys_ctrl_reg <= cell_single_config ? ovstr_pkg::SYS_RESET_SINGLE
                                               : ovstr_pkg::SYS_RESET_MULTI;
        end else begin
            sys_ctrl_reg <= sys_ctrl_next;
        end
    end

    // a written zero-to-one edge of the swap bit starts the blanking window
    assign swap_rise = wr_sys && reg_wr_data[ovstr_pkg::SWAP_BIT]
                       && !sys_ctrl_reg[ovstr_pkg::SWAP_BIT]
                       && !high_impedance_enable;
    assign tmr_if.start  = swap_rise;
    assign tmr_if.length = BLANK_CYCLES[ovstr_pkg::BLANK_CNT_W-1:0];

    ovstr_blank_timer u_blank_timer (
        .core_clk (core_clk),
        .srst     (srst),
        .tmr      (tmr_if.timer)
    );

    // candidate setpoint: staged low byte plus the high byte being written
    assign otg_cand      = {reg_wr_data, otg_lo_stage_reg};
    assign otg_cand_mv   = {1'b0, otg_cand[ovstr_pkg::OTG_FIELD_MSB:ovstr_pkg::OTG_FIELD_LSB], 3'h0};
    assign otg_cand_rsvd = |otg_cand[ovstr_pkg::OTG_RSVD_MSB:ovstr_pkg::OTG_RSVD_LSB];
    assign otg_cand_ok   = !otg_cand_rsvd
                           && otg_cand_mv >= ovstr_pkg::OTG_MIN_MV
                           && otg_cand_mv <= ovstr_pkg::OTG_MAX_MV;

    // low byte is staged, the whole word commits on the high byte write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            otg_lo_stage_reg <= ovstr_pkg::OTG_LO_STAGE_RESET;
        end else if (wr_otg_lo) begin
            otg_lo_stage_reg <= reg_wr_data;
        end
    end

    // accepted setpoint; rejected writes keep the previous word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            otg_reg <= ovstr_pkg::OTG_RESET;
        end else if (wr_otg_hi && otg_cand_ok) begin
            otg_reg <= {2'h0, otg_cand[ovstr_pkg::OTG_FIELD_MSB:ovstr_pkg::OTG_FIELD_LSB], 2'h0};
        end
    end

    // one-cycle flag for a refused setpoint write
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rejected_reg <= 1'b0;
        end else begin
            rejected_reg <= wr_otg_hi && !otg_cand_ok;
        end
    end

    // threshold decode: offset plus 100 mV steps, single cell keeps three bits
    assign sys_code     = sys_ctrl_reg[ovstr_pkg::SYS_FIELD_MSB:ovstr_pkg::SYS_FIELD_LSB];
    assign sys_code_eff = single_reg ? {3'h0, sys_code[2:0]} : sys_code;
    assign sys_own_mv   = ovstr_pkg::SYS_OFFSET_MV + {10'h000, sys_code_eff} * ovstr_pkg::SYS_STEP_MV;

    // otg decode at 8 mV per step, held inside the legal window
    always_comb begin
        otg_dec_mv = {1'b0, otg_reg[ovstr_pkg::OTG_FIELD_MSB:ovstr_pkg::OTG_FIELD_LSB], 3'h0};
        if (otg_dec_mv < ovstr_pkg::OTG_MIN_MV) begin
            otg_dec_mv = ovstr_pkg::OTG_MIN_MV;
        end else if (otg_dec_mv > ovstr_pkg::OTG_MAX_MV) begin
            otg_dec_mv = ovstr_pkg::OTG_MAX_MV;
        end
    end

    // registered decoded outputs; tracking substitutes the first threshold
    always_ff @(posedge core_clk) begin
        if (srst) begin
            second_mv_reg <= '0;
            otg_mv_reg    <= '0;
        end else begin
            second_mv_reg <= sys_ctrl_reg[ovstr_pkg::TRACK_BIT] ? sys_droop_threshold_first_mv
                                                                : sys_own_mv;
            otg_mv_reg    <= otg_dec_mv;
        end
    end

    // read port: data one cycle after the request, unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_rd_en;
            if (reg_rd_en && reg_addr == ovstr_pkg::ADDR_SYS_CTRL) begin
                rd_data_reg <= sys_ctrl_reg;
            end else if (reg_rd_en && reg_addr == ovstr_pkg::ADDR_OTG_LO) begin
                rd_data_reg <= otg_reg[7:0];
            end else if (reg_rd_en && reg_addr == ovstr_pkg::ADDR_OTG_HI) begin
                rd_data_reg <= otg_reg[15:8];
            end else begin
                rd_data_reg <= 8'h00;
            end
        end
    end

    // outputs straight from flip-flops
    assign reg_rd_data                   = rd_data_reg;
    assign reg_rd_valid                  = rd_valid_reg;
    assign sys_droop_threshold_second_mv = second_mv_reg;
    assign threshold_track_enable        = sys_ctrl_reg[ovstr_pkg::TRACK_BIT];
    assign fast_swap_enable              = sys_ctrl_reg[ovstr_pkg::SWAP_BIT];
    assign power_stage_disable           = tmr_if.busy;
    assign otg_voltage_mv                = otg_mv_reg;
    assign otg_write_rejected            = rejected_reg;

    // checks on the block's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_swap_hiz_force: assert property (high_impedance_enable |=> !fast_swap_enable)
        else $error("swap enable set while high impedance active");

    chk_blank_start: assert property (swap_rise |=> power_stage_disable [*8])
        else $error("power stage not blanked after swap enable rise");

    chk_blank_quiet: assert property (!power_stage_disable && !swap_rise |=> !power_stage_disable)
        else $error("power stage blanked without cause");

    chk_otg_reject_keep: assert property (wr_otg_hi && !otg_cand_ok |=> $stable(otg_reg) && otg_write_rejected)
        else $error("rejected setpoint write changed the register");

    chk_otg_rsvd_invalid: assert property (wr_otg_hi && reg_wr_data[7:6] != 2'h0 |=> $stable(otg_reg))
        else $error("reserved high bits accepted");

    chk_otg_accept_write: assert property (wr_otg_hi && otg_cand_ok |=> otg_reg[13:2] == $past(otg_cand[13:2]))
        else $error("valid setpoint write not stored");

    chk_otg_low_rsvd: assert property (otg_reg[1:0] == 2'h0)
        else $error("reserved low setpoint bits not zero");

    chk_otg_range_out: assert property (!srst |=> otg_voltage_mv >= 16'h0bb8 && otg_voltage_mv <= 16'h5dc0)
        else $error("otg voltage out of window");

    chk_otg_decode: assert property (!srst |=> otg_voltage_mv == {1'b0, $past(otg_reg[13:2]), 3'h0})
        else $error("otg voltage decode wrong");

    chk_otg_reset_val: assert property ($past(srst) |-> otg_reg == 16'h09c4)
        else $error("otg setpoint reset value wrong");

    chk_sys_reset_val: assert property ($past(srst) |-> sys_ctrl_reg == ($past(cell_single_config) ? 8'h04 : 8'h2c))
        else $error("control byte reset value wrong");

    chk_track_follow: assert property (threshold_track_enable |=> sys_droop_threshold_second_mv
                                       == $past(sys_droop_threshold_first_mv))
        else $error("second threshold does not follow first");

    chk_sys_decode: assert property (!srst && !threshold_track_enable && !single_reg |=> sys_droop_threshold_second_mv
                                     == 16'h0c80 + 16'h0064 * {10'h000, $past(sys_ctrl_reg[7:2])})
        else $error("threshold decode wrong");

    chk_single_limit: assert property (!threshold_track_enable && single_reg |=> sys_droop_threshold_second_mv
                                       <= 16'h0f3c)
        else $error("single cell threshold above limit");

    // registers move only on their own strobes, except the swap bit, which high impedance clears
    chk_otg_quiet_keep: assert property (!wr_otg_hi |=> $stable(otg_reg))
        else $error("setpoint changed without a high byte write");

    chk_stage_quiet: assert property (!wr_otg_lo |=> $stable(otg_lo_stage_reg))
        else $error("staged low byte changed without a write");

    chk_sys_quiet_keep: assert property (!wr_sys |=> $stable(sys_ctrl_reg[7:1]))
        else $error("threshold field changed without a write");

    chk_swap_quiet_keep: assert property (!wr_sys && !high_impedance_enable |=> $stable(fast_swap_enable))
        else $error("swap enable changed without a write");

    chk_reject_quiet: assert property (!wr_otg_hi |=> !otg_write_rejected)
        else $error("reject flag without a high byte write");

    chk_otg_range_reg: assert property (otg_reg[13:2] >= 12'h177 && otg_reg[13:2] <= 12'hbb8)
        else $error("stored setpoint outside the legal window");

    // blanking start and its suppression by high impedance
    chk_blank_on_write: assert property (wr_sys && reg_wr_data[0] && !fast_swap_enable
                                         && !high_impedance_enable |=> power_stage_disable)
        else $error("swap enable written high without blanking");

    chk_hiz_no_blank: assert property (high_impedance_enable && !power_stage_disable
                                       |=> !power_stage_disable)
        else $error("blanking started while high impedance active");

    // single cell decode, read-back of reserved bits and reset state of the control bits
    chk_single_decode: assert property (!srst && !threshold_track_enable && single_reg
                                        |=> sys_droop_threshold_second_mv
                                        == 16'h0c80 + 16'h0064 * {13'h0000, $past(sys_ctrl_reg[4:2])})
        else $error("single cell threshold decode wrong");

    chk_rd_low_rsvd: assert property (!srst && reg_rd_en && reg_addr == 8'h06
                                      |=> reg_rd_data[1:0] == 2'h0)
        else $error("reserved low setpoint bits read as one");

    chk_rd_high_rsvd: assert property (!srst && reg_rd_en && reg_addr == 8'h07
                                       |=> reg_rd_data[7:6] == 2'h0)
        else $error("reserved high setpoint bits read as one");

    chk_rd_valid_follow: assert property (!srst |=> reg_rd_valid == $past(reg_rd_en))
        else $error("read valid does not follow the read strobe");

    chk_ctrl_reset_off: assert property ($past(srst) |-> !threshold_track_enable && !fast_swap_enable)
        else $error("control bits not off after reset");
endmodule
`default_nettype wire

// *** verif/ovstr_host_model.sv ***
// host model that drives the byte register port of the block
`timescale 1ns/10ps
`default_nettype none
module ovstr_host_model (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr_en,
    output logic      [7:0] reg_wr_data,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid
);
    // idle port at time zero
    initial begin
        reg_addr    = 8'h00;
        reg_wr_en   = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en   = 1'b0;
    end
    // one write strobe; released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge core_clk);
        reg_wr_en   <= 1'b0;
        reg_addr    <= ~a;
        reg_wr_data <= ~d;
        #1;
    endtask
    // one read strobe; data and valid are taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1;
        d = reg_rd_data;
        v = reg_rd_valid;
    endtask
    // setpoint goes low byte first, then the high byte commits it
    task automatic otg_set(input logic [15:0] w);
        wr(ovstr_pkg::ADDR_OTG_LO, w[7:0]);
        wr(ovstr_pkg::ADDR_OTG_HI, w[15:8]);
    endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the otg voltage and threshold registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        core_clk;
    logic        srst;
    logic        cell_single_config;
    logic        high_impedance_enable;
    logic [15:0] first_mv;
    logic [15:0] second_mv;
    logic        track_en;
    logic        swap_en;
    logic        stage_off;
    logic [15:0] otg_mv;
    logic        otg_rej;
    logic [7:0]  addr;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic        rd_valid;
    int          err_total = 0;
    int          cmp_count = 0;

    // short blanking so the window can be counted
    ovstr_regs #(.BLANK_CYCLES(20)) DUT (.core_clk(core_clk), .srst(srst), .reg_addr(addr),
        .reg_wr_en(wr_en), .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data(rd_data),
        .reg_rd_valid(rd_valid), .cell_single_config(cell_single_config),
        .high_impedance_enable(high_impedance_enable), .sys_droop_threshold_first_mv(first_mv),
        .sys_droop_threshold_second_mv(second_mv), .threshold_track_enable(track_en),
        .fast_swap_enable(swap_en), .power_stage_disable(stage_off), .otg_voltage_mv(otg_mv),
        .otg_write_rejected(otg_rej));
    // far-side host
    ovstr_host_model host (.core_clk(core_clk), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid));

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // two edges so the decoded outputs follow the registers
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic do_reset(input logic strap);
        @(posedge core_clk);
        srst               <= 1'b1;
        cell_single_config <= strap;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        settle();
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        host.rd(a, d, v);
        chk({what, " valid"}, {15'h0000, v}, 16'h0001);
        chk(what, {8'h00, d}, {8'h00, exp});
    endtask
    task automatic t_reset();
        rd_chk("otg lo", ovstr_pkg::ADDR_OTG_LO, 8'hc4);
        rd_chk("otg hi", ovstr_pkg::ADDR_OTG_HI, 8'h09);
        rd_chk("sys multi", ovstr_pkg::ADDR_SYS_CTRL, 8'h2c);
        rd_chk("unmapped", 8'h10, 8'h00);
        chk("otg mv reset", otg_mv, 16'd5000);
        chk("second mv reset", second_mv, 16'd4300);
        $display("test reset done");
    endtask
    task automatic t_thresh();
        host.wr(ovstr_pkg::ADDR_SYS_CTRL, 8'hfc);
        settle();
        chk("second top", second_mv, 16'd9500);
        host.wr(ovstr_pkg::ADDR_SYS_CTRL, 8'h00);
        settle();
        chk("second offset", second_mv, 16'd3200);
        host.wr(ovstr_pkg::ADDR_SYS_CTRL, 8'h02);
        settle();
        chk("track bit", {15'h0000, track_en}, 16'h0001);
        chk("second tracks", second_mv, first_mv);
        $display("test threshold done");
    endtask
    // setpoint write with expected refusal and resulting setpoint
    task automatic otg_try(input logic [15:0] w, input logic rej, input logic [15:0] mv);
        logic [15:0] rb;
        rb = (mv >> 3) << 2;
        host.otg_set(w);
        chk("reject pulse", {15'h0000, otg_rej}, {15'h0000, rej});
        settle();
        chk("otg mv", otg_mv, mv);
        rd_chk("readback lo", ovstr_pkg::ADDR_OTG_LO, rb[7:0]);
        rd_chk("readback hi", ovstr_pkg::ADDR_OTG_HI, rb[15:8]);
    endtask
    task automatic t_otg();
        otg_try(16'h1773, 1'b0, 16'd12000);
        otg_try(16'h5770, 1'b1, 16'd12000);
        otg_try(16'h05d8, 1'b1, 16'd12000);
        otg_try(16'h2ee4, 1'b1, 16'd12000);
        otg_try(16'h2ee0, 1'b0, 16'd24000);
        otg_try(16'h05dc, 1'b0, 16'd3000);
        otg_try(16'h3ffc, 1'b1, 16'd3000);
        $display("test otg done");
    endtask
    task automatic t_swap();
        int n;
        n = 0;
        // swap enable written while high impedance is off
        host.wr(ovstr_pkg::ADDR_SYS_CTRL, 8'h01);
        chk("swap on", {15'h0000, swap_en}, 16'h0001);
        while (stage_off === 1'b1 && n < 60) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        chk("blank length", 16'(n), 16'd20);
        @(posedge core_clk);
        high_impedance_enable <= 1'b1;
        settle();
        chk("swap forced", {15'h0000, swap_en}, 16'h0000);
        rd_chk("sys hiz", ovstr_pkg::ADDR_SYS_CTRL, 8'h00);
        @(posedge core_clk);
        high_impedance_enable <= 1'b0;
        $display("test swap done");
    endtask
    task automatic t_single();
        do_reset(1'b1);
        rd_chk("sys single", ovstr_pkg::ADDR_SYS_CTRL, 8'h04);
        chk("swap reset", {15'h0000, swap_en}, 16'h0000);
        host.wr(ovstr_pkg::ADDR_SYS_CTRL, 8'hfc);
        settle();
        chk("single cap", second_mv, 16'd3900);
        $display("test single cell done");
    endtask
    // main sequence
    initial begin
        srst                  = 1'b1;
        cell_single_config    = 1'b0;
        high_impedance_enable = 1'b0;
        first_mv              = 16'h1234;
        do_reset(1'b0);
        t_reset();
        t_thresh();
        t_otg();
        t_swap();
        t_single();
        close_out();
    end
    // watchdog against a hung handshake
    initial begin
        #20000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
